//--- common/rsap_cfg.svh
/*
 * Constants of the radio SPI access protocol: command codes, buffer
 * geometry and link timing counts.
 * Assumes a 20 MHz system clock on both ends of the link.
 */
`ifndef RSAP_CFG_SVH
`define RSAP_CFG_SVH

// ---------------------------------------------------------------
// Command byte layout
// ---------------------------------------------------------------
`define RSAP_CMD_REG_BIT 7
`define RSAP_CMD_WR_BIT 6
`define RSAP_CMD_SEL_HI 6
`define RSAP_CMD_SEL_LO 5
`define RSAP_REG_ADDR_HI 5
`define RSAP_SUB_FRD 2'h1
`define RSAP_SUB_FWR 2'h3
`define RSAP_SUB_SRD 2'h0
`define RSAP_SUB_SWR 2'h2

// ---------------------------------------------------------------
// Frame buffer and byte framing
// ---------------------------------------------------------------
`define RSAP_BUF_DEPTH 128
`define RSAP_ADDR_FIRST 8'h00
`define RSAP_ADDR_STEP 8'h01
`define RSAP_PHR_ADDR 7'h00
`define RSAP_BIT_LAST 3'h7
`define RSAP_BIT_FIRST 3'h0
`define RSAP_IDLE_BYTE 8'h00
`define RSAP_SYNC_DEV_INIT 3'h2
`define RSAP_SYNC_HOST_INIT 1'h1

// ---------------------------------------------------------------
// Link timing (host makes the serial clock by a divider)
// ---------------------------------------------------------------
`define RSAP_CLK_NS 50
`define RSAP_SCLK_PERIOD_NS 400
`define RSAP_SCLK_HALF ((`RSAP_SCLK_PERIOD_NS / 2) / `RSAP_CLK_NS)
`define RSAP_SEL_GAP_NS 200
`define RSAP_SEL_GAP ((`RSAP_SEL_GAP_NS + `RSAP_CLK_NS - 1) / `RSAP_CLK_NS)

`endif

//--- common/rsap_pkg.sv
/*
 * Types shared by both ends of the radio SPI access protocol.
 * Assumes rsap_cfg.svh is on the include path.
 */
package rsap_pkg;

   typedef logic [7:0] rsap_byte_t;

   // ------------------------------------------------------------
   // Device end: phase of the current transaction
   // ------------------------------------------------------------
   typedef enum logic [7:0] {
      DS_CMD  = 8'h01,
      DS_RRD  = 8'h02,
      DS_RWR  = 8'h04,
      DS_FRD  = 8'h08,
      DS_FWR  = 8'h10,
      DS_SRD  = 8'h20,
      DS_SWR  = 8'h40,
      DS_DONE = 8'h80
   } rsap_dev_st_t;

   typedef struct packed {
      rsap_dev_st_t st;
      logic sclk_prev;
      logic [2:0] bitcnt;
      rsap_byte_t rx;
      rsap_byte_t tx;
      logic [7:0] addr;
      logic adr_pend;
      logic [127:0][7:0] mem;
      logic [5:0] reg_addr;
      rsap_byte_t reg_wdata;
      logic reg_wr;
      logic viol;
      logic oe_n;
      rsap_byte_t rd_data;
   } rsap_dev_state_t;

   // ------------------------------------------------------------
   // Host end: serial clock generator states
   // ------------------------------------------------------------
   typedef enum logic [4:0] {
      HS_IDLE = 5'h01,
      HS_LOW  = 5'h02,
      HS_HIGH = 5'h04,
      HS_TAIL = 5'h08,
      HS_REST = 5'h10
   } rsap_host_st_t;

   typedef struct packed {
      rsap_host_st_t st;
      logic [3:0] cnt;
      logic [2:0] bitcnt;
      logic [7:0] left;
      logic first;
      rsap_byte_t sh;
      rsap_byte_t rx;
      logic sclk;
      logic sel_n;
      logic mosi;
      rsap_byte_t rd_data;
      logic rd_valid;
      logic wr_take;
      logic busy;
   } rsap_host_state_t;

endpackage : rsap_pkg

//--- common/rsap_if.sv
/*
 * The four-wire link between host and radio device.
 * Assumes a pull-up on the board: an undriven data-out line reads high.
 */
`timescale 1ns/100ps

interface rsap_if ();
   logic sclk;
   logic sel_n;
   logic mosi;
   logic miso;
   logic miso_oe_n;
   logic miso_line;

   // Wire level of the shared data-out line; pull-up when released
   assign miso_line = miso_oe_n ? 1'b1 : miso;

   modport dev (
      input sclk,
      input sel_n,
      input mosi,
      output miso,
      output miso_oe_n
   );

   modport host (
      output sclk,
      output sel_n,
      output mosi,
      input miso_line
   );
endinterface : rsap_if

//--- hw/rsap_sync.sv
/*
 * Two-flop synchroniser for a group of unrelated level inputs.
 * Assumes each bit is a slow level; bits are not coherent with each other.
 */
`timescale 1ns/100ps

module rsap_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } rsap_sync_state_t;

   rsap_sync_state_t q;
   rsap_sync_state_t d;

   // First stage feeds only the second stage
   always_comb begin
      d.s1 = din;
      d.s2 = q.s1;
   end

   // Reset to the idle level so no false edge is seen after reset
   always_ff @(posedge clk) begin
      if (!rstn) begin
         q.s1 <= INIT;
         q.s2 <= INIT;
      end else begin
         q <= d;
      end
   end

   assign dout = q.s2;
endmodule : rsap_sync

//--- hw/rsap_dev.sv
/*
 * Device end of the radio SPI access protocol: a mode-0 slave that
 * decodes a command byte and gives access to a register port and to
 * the 128-byte frame buffer, which this module holds.
 * Assumes the link clock is at most about a quarter of clk, so that
 * every edge of it is seen after two-flop synchronisation.
 */
`timescale 1ns/100ps
`include "rsap_cfg.svh"

module rsap_dev (
   input wire logic clk,
   input wire logic rstn,
   rsap_if.dev spi,
   output logic [5:0] reg_addr,
   output rsap_pkg::rsap_byte_t reg_wdata,
   output logic reg_wr,
   input wire rsap_pkg::rsap_byte_t reg_rdata,
   input wire rsap_pkg::rsap_byte_t lqi,
   input wire logic rx_wr,
   input wire logic [6:0] rx_addr,
   input wire rsap_pkg::rsap_byte_t rx_wdata,
   input wire logic [6:0] rd_addr,
   output rsap_pkg::rsap_byte_t rd_data,
   output logic buffer_access_violation_irq,
   output logic miso,
   output logic miso_oe_n
);
   import rsap_pkg::*;

   rsap_dev_state_t q;
   rsap_dev_state_t d;
   logic [2:0] pins_s;
   logic sclk_s;
   logic sel_s;
   logic mosi_s;

   // ------------------------------------------------------------
   // Link inputs, brought into the clk domain
   // ------------------------------------------------------------
   rsap_sync #(
      .W(3),
      .INIT(`RSAP_SYNC_DEV_INIT)
   ) u_sync (
      .clk(clk),
      .rstn(rstn),
      .din({spi.sclk, spi.sel_n, spi.mosi}),
      .dout(pins_s)
   );

   assign sclk_s = pins_s[2];
   assign sel_s = pins_s[1];
   assign mosi_s = pins_s[0];

   // ------------------------------------------------------------
   // Protocol engine
   // ------------------------------------------------------------
   // Edges are found on the synchronised clock; rising and falling
   // can never fall in the same cycle, so the two branches are apart.
   always_comb begin
      logic rise;
      logic fall;
      logic [7:0] byte_in;
      logic [7:0] flen_p1;
      rsap_byte_t tx_next;
      rise = 1'b0;
      fall = 1'b0;
      byte_in = `RSAP_IDLE_BYTE;
      flen_p1 = `RSAP_ADDR_FIRST;
      tx_next = `RSAP_IDLE_BYTE;
      d = q;
      d.reg_wr = 1'b0;
      d.viol = 1'b0;
      d.sclk_prev = sclk_s;
      d.oe_n = sel_s;
      rise = sclk_s & ~q.sclk_prev;
      fall = ~sclk_s & q.sclk_prev;
      byte_in = {q.rx[6:0], mosi_s};
      // Stored length plus one is where the quality byte sits
      flen_p1 = {1'b0, q.mem[`RSAP_PHR_ADDR][6:0]} + `RSAP_ADDR_STEP;

      // Radio side of the buffer; a link write below wins a clash
      d.rd_data = q.mem[rd_addr];
      if (rx_wr) begin
         d.mem[rx_addr] = rx_wdata;
      end

      // Byte to present at the start of the next byte slot
      unique case (q.st)
         DS_RRD: tx_next = reg_rdata;
         DS_FRD: begin
            if (q.addr < flen_p1) begin
               tx_next = q.mem[q.addr[6:0]];
            end else if (q.addr == flen_p1) begin
               tx_next = lqi;
            end
         end
         DS_SRD: begin
            if (!q.adr_pend) begin
               tx_next = q.mem[q.addr[6:0]];
            end
         end
         DS_CMD, DS_RWR, DS_FWR, DS_SWR, DS_DONE: begin
            tx_next = `RSAP_IDLE_BYTE;
         end
      endcase

      if (sel_s) begin
         // Released: any partial byte is dropped, framing restarts;
         // buffer and length are untouched, so a cut read is harmless
         d.st = DS_CMD;
         d.bitcnt = `RSAP_BIT_FIRST;
         d.adr_pend = 1'b0;
         d.tx = `RSAP_IDLE_BYTE;
      end else if (rise) begin
         // Sample data-in on the rising edge, MSB first
         d.rx = byte_in;
         d.bitcnt = q.bitcnt + 3'h1;
         if (q.bitcnt == `RSAP_BIT_LAST) begin
            unique case (q.st)
               DS_CMD: begin
                  // Only bits 7..5 pick the mode
                  if (byte_in[`RSAP_CMD_REG_BIT]) begin
                     d.reg_addr = byte_in[`RSAP_REG_ADDR_HI:0];
                     d.st = byte_in[`RSAP_CMD_WR_BIT] ? DS_RWR
                                                      : DS_RRD;
                  end else begin
                     d.addr = `RSAP_ADDR_FIRST;
                     unique case (byte_in[`RSAP_CMD_SEL_HI:
                                          `RSAP_CMD_SEL_LO])
                        `RSAP_SUB_FRD: d.st = DS_FRD;
                        `RSAP_SUB_FWR: d.st = DS_FWR;
                        `RSAP_SUB_SRD: d.st = DS_SRD;
                        `RSAP_SUB_SWR: d.st = DS_SWR;
                     endcase
                     d.adr_pend = ~byte_in[`RSAP_CMD_SEL_LO];
                  end
               end
               DS_RWR: begin
                  d.reg_wdata = byte_in;
                  d.reg_wr = 1'b1;
                  d.st = DS_DONE;
               end
               DS_RRD: d.st = DS_DONE;
               DS_FRD: begin
                  // Past the quality byte there is nothing to read
                  if (q.addr > flen_p1) begin
                     d.viol = 1'b1;
                  end else begin
                     d.addr = q.addr + `RSAP_ADDR_STEP;
                  end
               end
               DS_FWR: begin
                  // Writing beyond the last buffer byte is refused
                  if (q.addr[7]) begin
                     d.viol = 1'b1;
                  end else begin
                     d.mem[q.addr[6:0]] = byte_in;
                     d.addr = q.addr + `RSAP_ADDR_STEP;
                  end
               end
               DS_SRD, DS_SWR: begin
                  if (q.adr_pend) begin
                     // Top bit dropped: no guard beyond the buffer
                     d.addr = {1'b0, byte_in[6:0]};
                     d.adr_pend = 1'b0;
                  end else begin
                     if (q.st == DS_SWR) begin
                        d.mem[q.addr[6:0]] = byte_in;
                     end
                     d.addr = {1'b0, q.addr[6:0] + 7'h01};
                  end
               end
               DS_DONE: d.st = DS_DONE;
            endcase
         end
      end else if (fall) begin
         // Data-out changes on the falling edge only
         if (q.bitcnt == `RSAP_BIT_FIRST) begin
            d.tx = tx_next;
         end else begin
            d.tx = {q.tx[6:0], 1'b0};
         end
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   // The whole buffer resets too; costly but keeps reads defined
   always_ff @(posedge clk) begin
      if (!rstn) begin
         q <= '0;
         q.st <= DS_CMD;
         q.oe_n <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // ------------------------------------------------------------
   // Outputs, all straight from the state register
   // ------------------------------------------------------------
   assign reg_addr = q.reg_addr;
   assign reg_wdata = q.reg_wdata;
   assign reg_wr = q.reg_wr;
   assign rd_data = q.rd_data;
   assign buffer_access_violation_irq = q.viol;
   assign miso = q.tx[7];
   assign miso_oe_n = q.oe_n;
   assign spi.miso = q.tx[7];
   assign spi.miso_oe_n = q.oe_n;
endmodule : rsap_dev

//--- hw/rsap_host.sv
/*
 * Host end of the radio SPI access protocol: a mode-0 master that
 * sends one command byte and a given number of further bytes.
 * Assumes the user offers each next byte on wr_data before it is
 * taken, and that the device runs on a clock of similar rate.
 */
`timescale 1ns/100ps
`include "rsap_cfg.svh"

module rsap_host (
   input wire logic clk,
   input wire logic rstn,
   input wire logic start,
   input wire rsap_pkg::rsap_byte_t cmd,
   input wire logic [7:0] nbytes,
   input wire rsap_pkg::rsap_byte_t wr_data,
   output logic wr_take,
   output rsap_pkg::rsap_byte_t rd_data,
   output logic rd_valid,
   output logic busy,
   rsap_if.host spi
);
   import rsap_pkg::*;

   rsap_host_state_t q;
   rsap_host_state_t d;
   logic miso_s;
   logic half_done;

   // ------------------------------------------------------------
   // Returned data, brought into the clk domain
   // ------------------------------------------------------------
   rsap_sync #(
      .W(1),
      .INIT(`RSAP_SYNC_HOST_INIT)
   ) u_sync (
      .clk(clk),
      .rstn(rstn),
      .din(spi.miso_line),
      .dout(miso_s)
   );

   assign half_done = (q.cnt == 4'(`RSAP_SCLK_HALF - 1));

   // ------------------------------------------------------------
   // Clock divider and byte sequencer
   // ------------------------------------------------------------
   // Data-in is taken at the end of the high phase, not at the rise:
   // the device answer needs more than a whole phase to cross both syncs.
   always_comb begin
      logic [7:0] byte_in;
      byte_in = {q.rx[6:0], miso_s};
      d = q;
      d.rd_valid = 1'b0;
      d.wr_take = 1'b0;
      d.cnt = q.cnt + 4'h1;
      unique case (q.st)
         HS_IDLE: begin
            d.cnt = 4'h0;
            if (start) begin
               d.sel_n = 1'b0;
               d.sh = cmd;
               d.mosi = cmd[7];
               d.left = nbytes;
               d.bitcnt = `RSAP_BIT_FIRST;
               d.first = 1'b1;
               d.busy = 1'b1;
               d.st = HS_LOW;
            end
         end
         HS_LOW: begin
            if (half_done) begin
               d.cnt = 4'h0;
               d.sclk = 1'b1;
               d.st = HS_HIGH;
            end
         end
         HS_HIGH: begin
            if (half_done) begin
               d.cnt = 4'h0;
               d.sclk = 1'b0;
               d.rx = byte_in;
               d.bitcnt = q.bitcnt + 3'h1;
               d.st = HS_LOW;
               d.sh = {q.sh[6:0], 1'b0};
               d.mosi = q.sh[6];
               if (q.bitcnt == `RSAP_BIT_LAST) begin
                  // The command slot answer is never passed on
                  d.rd_valid = ~q.first;
                  d.rd_data = byte_in;
                  d.first = 1'b0;
                  if (q.left == 8'h00) begin
                     d.st = HS_TAIL;
                  end else begin
                     // Filler in read slots is still a real level
                     d.left = q.left - 8'h01;
                     d.sh = wr_data;
                     d.mosi = wr_data[7];
                     d.wr_take = 1'b1;
                  end
               end
            end
         end
         HS_TAIL: begin
            if (half_done) begin
               d.cnt = 4'h0;
               d.sel_n = 1'b1;
               d.st = HS_REST;
            end
         end
         HS_REST: begin
            // Select stays high long enough for the device to see it
            if (q.cnt == 4'(`RSAP_SEL_GAP - 1)) begin
               d.cnt = 4'h0;
               d.busy = 1'b0;
               d.st = HS_IDLE;
            end
         end
      endcase
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rstn) begin
         q <= '0;
         q.st <= HS_IDLE;
         q.sel_n <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign wr_take = q.wr_take;
   assign rd_data = q.rd_data;
   assign rd_valid = q.rd_valid;
   assign busy = q.busy;
   assign spi.sclk = q.sclk;
   assign spi.sel_n = q.sel_n;
   assign spi.mosi = q.mosi;
endmodule : rsap_host

//--- verif/rsap_properties.sv
/*
 * Link checker for the four-wire link between host and device.
 * Assumes it sits beside the interface, with signals passed as inputs.
 */
`timescale 1ns/100ps

module rsap_properties (
   input wire logic clk,
   input wire logic rstn,
   input wire logic sclk,
   input wire logic sel_n,
   input wire logic mosi,
   input wire logic miso,
   input wire logic miso_oe_n
);
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   logic sclk_q;
   logic [2:0] rise_q;
   logic [2:0] rise_d;

   // Serial clock rises within a frame, modulo one byte
   always_comb begin
      rise_d = rise_q;
      if (sel_n) begin
         rise_d = 3'h0;
      end else if (sclk && !sclk_q) begin
         rise_d = rise_q + 3'h1;
      end
   end

   // Counter register; cleared in reset so a new run starts framed
   always_ff @(posedge clk) begin
      if (!rstn) begin
         sclk_q <= 1'b0;
         rise_q <= 3'h0;
      end else begin
         sclk_q <= sclk;
         rise_q <= rise_d;
      end
   end

   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   sequence s_high_phase;
      sclk[*4];
   endsequence
   sequence s_lead_in;
      (!sclk)[*4];
   endsequence

   property p_oe_off;
      sel_n[*5] |-> miso_oe_n;
   endproperty
   property p_oe_on;
      (!sel_n)[*5] |-> !miso_oe_n;
   endproperty
   property p_miso_fall;
      (!miso_oe_n && $changed(miso)) |-> !sclk;
   endproperty
   property p_mosi_hold;
      sclk |-> $stable(mosi);
   endproperty
   property p_sel_lead;
      $fell(sel_n) |-> s_lead_in;
   endproperty
   property p_idle_low;
      sel_n |-> !sclk;
   endproperty
   property p_half;
      $rose(sclk) |-> s_high_phase ##1 !sclk;
   endproperty
   property p_whole;
      $rose(sel_n) |-> rise_q == 3'h0;
   endproperty

   a_oe_off: assert property (p_oe_off)
      else $error("data-out driven while deselected");
   a_oe_on: assert property (p_oe_on)
      else $error("data-out not driven while selected");
   a_miso_fall: assert property (p_miso_fall)
      else $error("data-out changed during clock high");
   a_mosi_hold: assert property (p_mosi_hold)
      else $error("data-in changed during clock high");
   a_sel_lead: assert property (p_sel_lead)
      else $error("clock rose too soon after select");
   a_idle_low: assert property (p_idle_low)
      else $error("serial clock not low while idle");
   a_half: assert property (p_half)
      else $error("clock high phase not four cycles");
   a_whole: assert property (p_whole)
      else $error("frame ended inside a byte");
endmodule : rsap_properties

//--- verif/rsap_tb.sv
/*
 * Self-checking bench: host and device ends joined by one link.
 * Assumes both ends share one 20 MHz clock and a synchronous reset.
 */
`timescale 1ns/100ps

module rsap_tb;
   import rsap_pkg::*;
   logic clk, rstn, start, rx_wr, reg_wr, rd_valid, busy, wr_take, irq;
   rsap_byte_t cmd, wr_data, rd_data, reg_wdata, lqi, rx_wdata, buf_q;
   rsap_byte_t reg_rdata;
   logic [7:0] nbytes;
   logic [5:0] reg_addr;
   logic [6:0] rx_addr, rd_addr;
   rsap_byte_t regs [64];
   rsap_byte_t tx [132];
   rsap_byte_t rx [132];
   int n_fail, cmp_count, n_viol, n_regwr, k;

   rsap_if spi ();
   rsap_host i_rsap_host (.clk(clk), .rstn(rstn), .start(start),
      .cmd(cmd), .nbytes(nbytes), .wr_data(wr_data), .wr_take(wr_take),
      .rd_data(rd_data), .rd_valid(rd_valid), .busy(busy), .spi(spi.host));
   rsap_dev i_rsap_dev (.clk(clk), .rstn(rstn), .spi(spi.dev),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rdata(reg_rdata), .lqi(lqi), .rx_wr(rx_wr), .rx_addr(rx_addr),
      .rx_wdata(rx_wdata), .rd_addr(rd_addr), .rd_data(buf_q),
      .buffer_access_violation_irq(irq), .miso(), .miso_oe_n());
   rsap_properties i_rsap_properties (.clk(clk), .rstn(rstn),
      .sclk(spi.sclk), .sel_n(spi.sel_n), .mosi(spi.mosi),
      .miso(spi.miso), .miso_oe_n(spi.miso_oe_n));

   // ---------------------------------------------------------------
   // Clock, register stand-in and event counters
   // ---------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Combinational read, as the device fetches it at the falling edge that ends the command byte
   assign reg_rdata = regs[reg_addr];

   always @(negedge clk) begin
      if (reg_wr === 1'b1) begin
         regs[reg_addr] = reg_wdata;
         n_regwr++;
      end
      if (irq === 1'b1) begin
         n_viol++;
      end
   end

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic chk(input rsap_byte_t seen, input rsap_byte_t exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen,
            exp);
      end
   endtask : chk

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : wrap_up

   // One transaction: command, then n bytes from tx; returns into rx
   task automatic xfer(input rsap_byte_t c, input int n);
      int g;
      int t;
      int r;
      logic took;
      t = 0;
      r = 0;
      took = 1'b0;
      wr_data = tx[0];
      cmd = c;
      nbytes = n[7:0];
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      // Byte is held until the cycle after the take pulse has passed
      for (g = 0; g < 12000 && busy === 1'b1; g++) begin
         @(negedge clk);
         if (took) begin
            t++;
            wr_data = tx[t];
         end
         took = (wr_take === 1'b1);
         if (rd_valid === 1'b1 && r < 132) begin
            rx[r] = rd_data;
            r++;
         end
      end
      if (g == 12000) begin
         n_fail++;
         wrap_up();
      end
   endtask : xfer

   // Buffer content through the local read port, one cycle latency
   task automatic peek(input int a, input rsap_byte_t e);
      rd_addr = a[6:0];
      @(negedge clk);
      chk(buf_q, e);
   endtask : peek

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      rstn = 1'b0;
      start = 1'b0;
      cmd = 8'h00;
      nbytes = 8'h00;
      wr_data = 8'h00;
      lqi = 8'hD7;
      rx_wr = 1'b0;
      rx_addr = 7'h00;
      rx_wdata = 8'h00;
      rd_addr = 7'h00;
      n_fail = 0;
      cmp_count = 0;
      n_viol = 0;
      n_regwr = 0;
      for (k = 0; k < 64; k++) regs[k] = 8'h5A ^ k[7:0];
      repeat (20) @(negedge clk);
      rstn = 1'b1;
      repeat (4) @(negedge clk);

      // Register write, read back, read of an untouched register
      tx[0] = 8'h3C;
      xfer(8'hC5, 1);
      chk(regs[5], 8'h3C);
      xfer(8'h85, 1);
      chk(rx[0], 8'h3C);
      xfer(8'hBF, 1);
      chk(rx[0], 8'h65);
      chk(n_regwr[7:0], 8'h01);
      $display("test register done");

      // Short frame written with reserved bits set, then read past end
      tx[0] = 8'h03;
      tx[1] = 8'h11;
      tx[2] = 8'h22;
      tx[3] = 8'h33;
      xfer(8'h7F, 4);
      for (k = 0; k < 4; k++) peek(k, tx[k]);
      xfer(8'h3F, 6);
      for (k = 0; k < 4; k++) chk(rx[k], tx[k]);
      chk(rx[4], lqi);
      chk(rx[5], 8'h00);
      chk(n_viol[7:0], 8'h01);
      $display("test frame done");

      // Frame read cut after the length byte leaves everything intact
      xfer(8'h20, 1);
      chk(rx[0], 8'h03);
      for (k = 0; k < 4; k++) peek(k, tx[k]);
      chk(n_viol[7:0], 8'h01);
      $display("test early end done");

      // Random write up to the top address, then read back
      tx[0] = 8'h7D;
      tx[1] = 8'hAA;
      tx[2] = 8'hBB;
      tx[3] = 8'hCC;
      xfer(8'h40, 4);
      for (k = 1; k < 4; k++) peek(8'h7C + k, tx[k]);
      xfer(8'h00, 4);
      for (k = 1; k < 4; k++) chk(rx[k], tx[k]);
      // Radio side write seen through a random read
      rx_wr = 1'b1;
      rx_addr = 7'h10;
      rx_wdata = 8'h5E;
      @(negedge clk);
      rx_wr = 1'b0;
      tx[0] = 8'h10;
      xfer(8'h1F, 2);
      chk(rx[1], 8'h5E);
      $display("test random done");

      // Longest frame plus one refused byte, then full read back
      tx[0] = 8'h7F;
      for (k = 1; k < 129; k++) tx[k] = k[7:0] ^ 8'h80;
      xfer(8'h60, 129);
      chk(n_viol[7:0], 8'h02);
      peek(127, tx[127]);
      xfer(8'h20, 129);
      for (k = 0; k < 128; k++) chk(rx[k], tx[k]);
      chk(rx[128], lqi);
      chk(n_viol[7:0], 8'h02);
      $display("test long frame done");
      wrap_up();
   end
endmodule : rsap_tb
